// ===== accr_bank.sv
// Channel 4/5 configuration and channel 4 calibration register bank
// Function
// R1: Each channel configuration keeps a 10-bit two's complement phase delay in bits 15:6.
// R2: Configuration bits 5:3 read zero and ignore writes.
// R3: Channel 4 bit 2 set turns its DC filter off, clear follows the global setting.
// R4: Bits 1:0 pick own pair, shorted inputs, positive or negative test signal.
// R5: Channel 4 offset is 24-bit signed, upper word bits 23:8, lower word 15:8 bits 7:0.
// R6: Low byte of the offset and gain lower words is reserved and reads zero.
// R7: Channel 4 gain is 24-bit unsigned split the same way, spanning 0.0 to below 2.0.
// R8: After reset gain upper reads 8000h and the other calibration words read 0000h.
// R9: After reset both configuration registers read 0000h.
// R10: Channel 4 words sit at 1Dh..21h in order, channel 5 configuration at 22h.
// R11: Channel 5 configuration has the same layout and acts only on channel 5.
// R12: Each channel 4 sample is corrected by stored offset and gain, new values on next samples.
`timescale 1ns/1ns
`include "accr_regs.svh"
module accr_bank
	import accr_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int SAMPLE_W = 24
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_global_dc_filter_setting,
	output logic [9:0] o_chan4_phase_delay,
	output logic o_chan4_dc_filter_en,
	output logic [1:0] o_chan4_input_select,
	output logic [9:0] o_chan5_phase_delay,
	output logic o_chan5_dc_filter_en,
	output logic [1:0] o_chan5_input_select,
	input wire logic [SAMPLE_W-1:0] i_chan4_sample,
	input wire logic i_chan4_sample_valid,
	output logic [SAMPLE_W-1:0] o_chan4_result,
	output logic o_chan4_result_valid
);

	initial begin
		if (ADDR_W < 6 || SAMPLE_W != 24) begin
			$error("accr_bank: unsupported parameter values");
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
		addr_hit = (a == ADDR_W'(off));
	endfunction : addr_hit

	function automatic accr_cfg_s cfg_unpack(input logic [15:0] w);
		accr_cfg_s c;
		c.phase_delay = w[`ACCR_PHASE_MSB:`ACCR_PHASE_LSB]; // [R1]
		c.dc_filter_off = w[`ACCR_DCOFF_BIT]; // [R3] [R11]
		c.input_select = accr_sel_e'(w[`ACCR_SEL_MSB:`ACCR_SEL_LSB]); // [R4]
		cfg_unpack = c;
	endfunction : cfg_unpack

	function automatic logic [15:0] cfg_pack(input accr_cfg_s c);
		cfg_pack = {c.phase_delay, `ACCR_CFG_RSV, c.dc_filter_off, c.input_select}; // [R2]
	endfunction : cfg_pack

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	accr_state_s st_r;
	accr_state_s st_nxt;
	logic signed [25:0] corr_sum;
	logic signed [49:0] corr_prod;
	logic signed [25:0] corr_scaled;

	always_comb begin
		st_nxt = st_r;
		st_nxt.result_valid = 1'b0;
		// Register writes
		if (i_wr) begin
			if (addr_hit(i_addr, `ACCR_OFF_C4_CFG)) begin // [R10]
				st_nxt.chan4_cfg = cfg_unpack(i_wdata);
			end
			if (addr_hit(i_addr, `ACCR_OFF_C5_CFG)) begin // [R10] [R11]
				st_nxt.chan5_cfg = cfg_unpack(i_wdata);
			end
			if (addr_hit(i_addr, `ACCR_OFF_C4_OFS_HI)) begin // [R5]
				st_nxt.chan4_offset[`ACCR_CAL_HI] = i_wdata;
			end
			if (addr_hit(i_addr, `ACCR_OFF_C4_OFS_LO)) begin // [R5] [R6]
				st_nxt.chan4_offset[`ACCR_CAL_LO] = i_wdata[`ACCR_LOBYTE_MSB:`ACCR_LOBYTE_LSB];
			end
			if (addr_hit(i_addr, `ACCR_OFF_C4_GAIN_HI)) begin // [R7]
				st_nxt.chan4_gain[`ACCR_CAL_HI] = i_wdata;
			end
			if (addr_hit(i_addr, `ACCR_OFF_C4_GAIN_LO)) begin // [R7] [R6]
				st_nxt.chan4_gain[`ACCR_CAL_LO] = i_wdata[`ACCR_LOBYTE_MSB:`ACCR_LOBYTE_LSB];
			end
		end
		// Read data, valid only in the cycle after the strobe
		st_nxt.rdata = `ACCR_ZERO16;
		if (i_rd) begin
			unique case (1'b1)
				addr_hit(i_addr, `ACCR_OFF_C4_CFG): st_nxt.rdata = cfg_pack(st_r.chan4_cfg);
				addr_hit(i_addr, `ACCR_OFF_C5_CFG): st_nxt.rdata = cfg_pack(st_r.chan5_cfg);
				addr_hit(i_addr, `ACCR_OFF_C4_OFS_HI): st_nxt.rdata = st_r.chan4_offset[`ACCR_CAL_HI];
				addr_hit(i_addr, `ACCR_OFF_C4_OFS_LO): begin
					st_nxt.rdata = {st_r.chan4_offset[`ACCR_CAL_LO], `ACCR_ZERO8}; // [R6]
				end
				addr_hit(i_addr, `ACCR_OFF_C4_GAIN_HI): st_nxt.rdata = st_r.chan4_gain[`ACCR_CAL_HI];
				addr_hit(i_addr, `ACCR_OFF_C4_GAIN_LO): begin
					st_nxt.rdata = {st_r.chan4_gain[`ACCR_CAL_LO], `ACCR_ZERO8}; // [R6]
				end
				default: st_nxt.rdata = `ACCR_ZERO16;
			endcase
		end
		// Sample correction: (x - offset) * gain / 2^23, saturated
		corr_sum = 26'(signed'(i_chan4_sample)) - 26'(signed'(st_r.chan4_offset)); // [R12]
		corr_prod = 50'(corr_sum) * 50'(signed'({1'b0, st_r.chan4_gain})); // [R7]
		corr_scaled = 26'(corr_prod >>> `ACCR_GAIN_ONE_SHIFT);
		if (i_chan4_sample_valid) begin // [R12]
			st_nxt.result_valid = 1'b1;
			if (corr_scaled > `ACCR_SUM_MAX) begin
				st_nxt.result = `ACCR_SAT_POS;
			end else if (corr_scaled < `ACCR_SUM_MIN) begin
				st_nxt.result = `ACCR_SAT_NEG;
			end else begin
				st_nxt.result = corr_scaled[23:0];
			end
		end
		if (i_srst) begin
			st_nxt.chan4_cfg = cfg_unpack(`ACCR_RST_CFG); // [R9]
			st_nxt.chan5_cfg = cfg_unpack(`ACCR_RST_CFG); // [R9]
			st_nxt.chan4_offset = {`ACCR_RST_OFS_HI, `ACCR_RST_OFS_LO}; // [R8]
			st_nxt.chan4_gain = {`ACCR_RST_GAIN_HI, `ACCR_RST_GAIN_LO}; // [R8]
			st_nxt.rdata = `ACCR_ZERO16;
			st_nxt.result = '0;
			st_nxt.result_valid = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rdata = st_r.rdata;
	assign o_chan4_phase_delay = st_r.chan4_cfg.phase_delay; // [R1]
	assign o_chan4_input_select = st_r.chan4_cfg.input_select; // [R4]
	assign o_chan4_dc_filter_en = i_global_dc_filter_setting & ~st_r.chan4_cfg.dc_filter_off; // [R3]
	assign o_chan5_phase_delay = st_r.chan5_cfg.phase_delay; // [R11]
	assign o_chan5_input_select = st_r.chan5_cfg.input_select; // [R11]
	assign o_chan5_dc_filter_en = i_global_dc_filter_setting & ~st_r.chan5_cfg.dc_filter_off; // [R11]
	assign o_chan4_result = st_r.result;
	assign o_chan4_result_valid = st_r.result_valid;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_cfg_reserved_zero;
		@(posedge i_sys_clk) disable iff (i_srst)
		$past(i_rd) && ($past(i_addr) == ADDR_W'(`ACCR_OFF_C4_CFG)
			|| $past(i_addr) == ADDR_W'(`ACCR_OFF_C5_CFG)) |-> o_rdata[5:3] == 3'b000;
	endproperty
	a_cfg_reserved_zero: assert property (p_cfg_reserved_zero) // [R2]
		else $error("Reserved config bits read nonzero");

	property p_lo_reserved_zero;
		@(posedge i_sys_clk) disable iff (i_srst)
		$past(i_rd) && ($past(i_addr) == ADDR_W'(`ACCR_OFF_C4_OFS_LO)
			|| $past(i_addr) == ADDR_W'(`ACCR_OFF_C4_GAIN_LO)) |-> o_rdata[7:0] == 8'h00;
	endproperty
	a_lo_reserved_zero: assert property (p_lo_reserved_zero) // [R6]
		else $error("Reserved low byte read nonzero");

	property p_reset_values;
		@(posedge i_sys_clk)
		$past(i_srst) |-> st_r.chan4_gain == 24'h80_0000 && st_r.chan4_offset == 24'h00_0000
			&& cfg_pack(st_r.chan4_cfg) == 16'h0000 && cfg_pack(st_r.chan5_cfg) == 16'h0000;
	endproperty
	a_reset_values: assert property (p_reset_values) // [R8]
		else $error("Reset values wrong");

	property p_cfg_readback;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG) ##1 i_rd && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG)
			&& !i_srst |=> o_rdata == ($past(i_wdata, 2) & 16'hffc7);
	endproperty
	a_cfg_readback: assert property (p_cfg_readback) // [R1]
		else $error("Channel 4 config readback mismatch");

	property p_phase_out;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C5_CFG) |=> o_chan5_phase_delay == $past(i_wdata[15:6]);
	endproperty
	a_phase_out: assert property (p_phase_out) // [R11]
		else $error("Channel 5 phase delay not taken");

	property p_dc_filter;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG) && i_wdata[`ACCR_DCOFF_BIT]
			|=> !o_chan4_dc_filter_en;
	endproperty
	a_dc_filter: assert property (p_dc_filter) // [R3]
		else $error("Channel 4 DC filter not disabled");

	property p_select_out;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG) |=> o_chan4_input_select == $past(i_wdata[1:0]);
	endproperty
	a_select_out: assert property (p_select_out) // [R4]
		else $error("Channel 4 input select not taken");

	property p_offset_hi;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_OFS_HI) |=> st_r.chan4_offset[23:8] == $past(i_wdata);
	endproperty
	a_offset_hi: assert property (p_offset_hi) // [R5]
		else $error("Offset upper word not stored");

	property p_unity_gain;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_chan4_sample_valid && st_r.chan4_gain == 24'h80_0000 && st_r.chan4_offset == 24'h0
			|=> o_chan4_result_valid && o_chan4_result == $past(i_chan4_sample);
	endproperty
	a_unity_gain: assert property (p_unity_gain) // [R12]
		else $error("Unity gain correction changed the sample");

	property p_chan4_phase;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG) |=> o_chan4_phase_delay == $past(i_wdata[15:6]);
	endproperty
	a_chan4_phase: assert property (p_chan4_phase) // [R1]
		else $error("Channel 4 phase delay not taken");

	property p_dc_follow;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG) && !i_wdata[`ACCR_DCOFF_BIT]
			|=> o_chan4_dc_filter_en == i_global_dc_filter_setting;
	endproperty
	a_dc_follow: assert property (p_dc_follow) // [R3]
		else $error("Channel 4 DC filter does not follow the global setting");

	property p_chan5_select;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C5_CFG) |=> o_chan5_input_select == $past(i_wdata[1:0]);
	endproperty
	a_chan5_select: assert property (p_chan5_select) // [R11]
		else $error("Channel 5 input select not taken");

	property p_chan5_dc;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C5_CFG) && i_wdata[`ACCR_DCOFF_BIT]
			|=> !o_chan5_dc_filter_en;
	endproperty
	a_chan5_dc: assert property (p_chan5_dc) // [R11]
		else $error("Channel 5 DC filter not disabled");

	property p_offset_lo;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_OFS_LO)
			|=> st_r.chan4_offset[`ACCR_CAL_LO] == $past(i_wdata[15:8]);
	endproperty
	a_offset_lo: assert property (p_offset_lo) // [R5]
		else $error("Offset lower bits not stored");

	property p_offset_read;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_rd && i_addr == ADDR_W'(`ACCR_OFF_C4_OFS_HI)
			|=> o_rdata == $past(st_r.chan4_offset[`ACCR_CAL_HI]);
	endproperty
	a_offset_read: assert property (p_offset_read) // [R5]
		else $error("Offset upper word read wrong");

	property p_gain_hi;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_GAIN_HI)
			|=> st_r.chan4_gain[`ACCR_CAL_HI] == $past(i_wdata);
	endproperty
	a_gain_hi: assert property (p_gain_hi) // [R7]
		else $error("Gain upper word not stored");

	property p_gain_lo;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_GAIN_LO)
			|=> st_r.chan4_gain[`ACCR_CAL_LO] == $past(i_wdata[15:8]);
	endproperty
	a_gain_lo: assert property (p_gain_lo) // [R7]
		else $error("Gain lower bits not stored");

	property p_gain_read;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_rd && i_addr == ADDR_W'(`ACCR_OFF_C4_GAIN_HI)
			|=> o_rdata == $past(st_r.chan4_gain[`ACCR_CAL_HI]);
	endproperty
	a_gain_read: assert property (p_gain_read) // [R7]
		else $error("Gain upper word read wrong");

	property p_rdata_idle;
		@(posedge i_sys_clk) disable iff (i_srst)
		!i_rd |=> o_rdata == `ACCR_ZERO16;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // [R10]
		else $error("Read data nonzero without a read");

	property p_unmapped_read;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_rd && (i_addr < ADDR_W'(`ACCR_OFF_C4_CFG) || i_addr > ADDR_W'(`ACCR_OFF_C5_CFG))
			|=> o_rdata == `ACCR_ZERO16;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) // [R10]
		else $error("Unmapped index read nonzero");

	property p_result_valid_set;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_chan4_sample_valid |=> o_chan4_result_valid;
	endproperty
	a_result_valid_set: assert property (p_result_valid_set) // [R12]
		else $error("Result valid missing after a sample");

	property p_result_valid_clr;
		@(posedge i_sys_clk) disable iff (i_srst)
		!i_chan4_sample_valid |=> !o_chan4_result_valid;
	endproperty
	a_result_valid_clr: assert property (p_result_valid_clr) // [R12]
		else $error("Result valid without a sample");

	property p_result_hold;
		@(posedge i_sys_clk) disable iff (i_srst)
		!i_chan4_sample_valid |=> $stable(o_chan4_result);
	endproperty
	a_result_hold: assert property (p_result_hold) // [R12]
		else $error("Result changed without a sample");

	property p_sat_pos;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_chan4_sample_valid && i_chan4_sample == `ACCR_SAT_POS
			&& st_r.chan4_offset[`ACCR_SIGN_BIT] && st_r.chan4_gain[`ACCR_SIGN_BIT]
			|=> o_chan4_result == `ACCR_SAT_POS;
	endproperty
	a_sat_pos: assert property (p_sat_pos) // [R12]
		else $error("Positive overflow not saturated");

	property p_sat_neg;
		@(posedge i_sys_clk) disable iff (i_srst)
		i_chan4_sample_valid && i_chan4_sample == `ACCR_SAT_NEG
			&& !st_r.chan4_offset[`ACCR_SIGN_BIT] && |st_r.chan4_offset
			&& st_r.chan4_gain[`ACCR_SIGN_BIT] |=> o_chan4_result == `ACCR_SAT_NEG;
	endproperty
	a_sat_neg: assert property (p_sat_neg) // [R12]
		else $error("Negative overflow not saturated");

	c_cfg_write: cover property (@(posedge i_sys_clk) i_wr && i_addr == ADDR_W'(`ACCR_OFF_C4_CFG));
	c_gain_read: cover property (@(posedge i_sys_clk) i_rd && i_addr == ADDR_W'(`ACCR_OFF_C4_GAIN_HI));
	c_result: cover property (@(posedge i_sys_clk) o_chan4_result_valid);
	c_saturate: cover property (@(posedge i_sys_clk)
		o_chan4_result_valid && o_chan4_result == `ACCR_SAT_POS);
	c_unmapped: cover property (@(posedge i_sys_clk) i_rd && i_addr < ADDR_W'(`ACCR_OFF_C4_CFG));

endmodule : accr_bank

// ===== accr_regs.svh
// Register offsets, field positions and reset values of the channel calibration bank
`ifndef ACCR_REGS_SVH
`define ACCR_REGS_SVH
`define ACCR_OFF_C4_CFG 6'h1d
`define ACCR_OFF_C4_OFS_HI 6'h1e
`define ACCR_OFF_C4_OFS_LO 6'h1f
`define ACCR_OFF_C4_GAIN_HI 6'h20
`define ACCR_OFF_C4_GAIN_LO 6'h21
`define ACCR_OFF_C5_CFG 6'h22
`define ACCR_RST_CFG 16'h0000
`define ACCR_RST_OFS_HI 16'h0000
`define ACCR_RST_OFS_LO 8'h00
`define ACCR_RST_GAIN_HI 16'h8000
`define ACCR_RST_GAIN_LO 8'h00
`define ACCR_PHASE_MSB 15
`define ACCR_PHASE_LSB 6
`define ACCR_DCOFF_BIT 2
`define ACCR_SEL_MSB 1
`define ACCR_SEL_LSB 0
`define ACCR_LOBYTE_MSB 15
`define ACCR_LOBYTE_LSB 8
`define ACCR_ZERO16 16'h0000
`define ACCR_ZERO8 8'h00
`define ACCR_GAIN_ONE_SHIFT 23
`define ACCR_CAL_HI 23:8
`define ACCR_CAL_LO 7:0
`define ACCR_SIGN_BIT 23
`define ACCR_CFG_RSV 3'b000
`define ACCR_SAT_POS 24'h7f_ffff
`define ACCR_SAT_NEG 24'h80_0000
`define ACCR_SUM_MAX 26'sh07f_ffff
`define ACCR_SUM_MIN (-26'sh080_0000)
`endif

// ===== accr_pkg.sv
// Types shared by the channel calibration bank
package accr_pkg;
	typedef enum logic [1:0] {
		ACCR_SEL_PAIR = 2'b00,
		ACCR_SEL_SHORT = 2'b01,
		ACCR_SEL_TEST_POS = 2'b10,
		ACCR_SEL_TEST_NEG = 2'b11
	} accr_sel_e;
	typedef struct packed {
		logic [9:0] phase_delay;
		logic dc_filter_off;
		accr_sel_e input_select;
	} accr_cfg_s;
	typedef struct packed {
		accr_cfg_s chan4_cfg;
		accr_cfg_s chan5_cfg;
		logic [23:0] chan4_offset;
		logic [23:0] chan4_gain;
		logic [15:0] rdata;
		logic [23:0] result;
		logic result_valid;
	} accr_state_s;
endpackage : accr_pkg

// ===== accr_bank_bench.sv
// Self-checking bench of the channel calibration register bank
`timescale 1ns/1ns
module accr_bank_bench;
	// ----------------------------------------
	// Signals and reference model
	// ----------------------------------------
	logic i_sys_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_chan4_sample_valid = 0;
	logic i_global_dc_filter_setting = 0;
	logic [5:0] i_addr = '0;
	logic [15:0] i_wdata = '0;
	logic [23:0] i_chan4_sample = '0;
	logic [15:0] o_rdata;
	logic [9:0] o_chan4_phase_delay, o_chan5_phase_delay;
	logic [1:0] o_chan4_input_select, o_chan5_input_select;
	logic o_chan4_dc_filter_en, o_chan5_dc_filter_en, o_chan4_result_valid;
	logic [23:0] o_chan4_result, sx, sq;
	logic [15:0] rd_exp, rd_q;
	logic rd_pend = 0, sp = 0;
	int seed = 22220, n_mismatch = 0, checks_done = 0, k, j;
	localparam logic [5:0] ADR [7] = '{6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h1c};
	localparam logic [15:0] MSK [7] = '{16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00,
		16'hffc7, 16'h0000};
	localparam logic [15:0] RST [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000,
		16'h0000, 16'h0000};
	logic [15:0] m [7] = RST;
	accr_bank accr_bank_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_global_dc_filter_setting(i_global_dc_filter_setting),
		.o_chan4_phase_delay(o_chan4_phase_delay), .o_chan4_dc_filter_en(o_chan4_dc_filter_en),
		.o_chan4_input_select(o_chan4_input_select), .o_chan5_phase_delay(o_chan5_phase_delay),
		.o_chan5_dc_filter_en(o_chan5_dc_filter_en), .o_chan5_input_select(o_chan5_input_select),
		.i_chan4_sample(i_chan4_sample), .i_chan4_sample_valid(i_chan4_sample_valid),
		.o_chan4_result(o_chan4_result), .o_chan4_result_valid(o_chan4_result_valid));
	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// ----------------------------------------
	// Expectation and comparison
	// ----------------------------------------
	function automatic logic [23:0] corr(input logic [23:0] x, o, g);
		logic signed [49:0] p;
		p = ($signed({x[23], x}) - $signed({o[23], o})) * $signed({1'b0, g});
		p = p >>> 23;
		if (p > 50'sh7f_ffff) return 24'h7f_ffff;
		if (p < -50'sh80_0000) return 24'h80_0000;
		return p[23:0];
	endfunction : corr
	task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	always @(posedge i_sys_clk) begin
		rd_pend <= i_rd & ~i_srst;
		rd_q <= rd_exp;
		sp <= i_chan4_sample_valid & ~i_srst;
		sq <= i_srst ? 24'h00_0000 : (i_chan4_sample_valid ? sx : sq);
	end
	always @(negedge i_sys_clk) begin
		if (!i_srst) begin
			check("rdata", 24'(rd_pend ? rd_q : 16'h0000), 24'(o_rdata));
			check("c4_phase", 24'(m[0][15:6]), 24'(o_chan4_phase_delay));
			check("c4_sel", 24'(m[0][1:0]), 24'(o_chan4_input_select));
			check("c4_dc", 24'(i_global_dc_filter_setting & ~m[0][2]), 24'(o_chan4_dc_filter_en));
			check("c5_phase", 24'(m[5][15:6]), 24'(o_chan5_phase_delay));
			check("c5_sel", 24'(m[5][1:0]), 24'(o_chan5_input_select));
			check("c5_dc", 24'(i_global_dc_filter_setting & ~m[5][2]), 24'(o_chan5_dc_filter_en));
			check("rvalid", 24'(sp), 24'(o_chan4_result_valid));
			check("result", sq, o_chan4_result);
		end
	end
	// ----------------------------------------
	// Bus and sample drivers
	// ----------------------------------------
	task automatic drv(input logic w, input logic r, input logic v);
		i_wr <= w;
		i_rd <= r;
		i_chan4_sample_valid <= v;
	endtask : drv
	task automatic wr(input int n, input logic [15:0] d);
		drv(1, 0, 0);
		i_addr <= ADR[n];
		i_wdata <= d;
		i_global_dc_filter_setting <= ^d;
		@(posedge i_sys_clk);
		m[n] = d & MSK[n];
	endtask : wr
	task automatic rd(input int n);
		drv(0, 1, 0);
		i_addr <= ADR[n];
		rd_exp <= m[n];
		@(posedge i_sys_clk);
	endtask : rd
	task automatic smp(input logic [23:0] x);
		drv(0, 0, 1);
		i_chan4_sample <= x;
		sx <= corr(x, {m[1], m[2][15:8]}, {m[3], m[4][15:8]});
		@(posedge i_sys_clk);
	endtask : smp
	task automatic idle;
		drv(0, 0, 0);
		@(posedge i_sys_clk);
	endtask : idle
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge i_sys_clk);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_srst <= 0;
		for (k = 0; k < 7; k++) rd(k);
		smp(24'h7f_ffff);
		smp(24'h80_0000);
		repeat (4) smp(24'($random(seed)));
		idle();
		$display("test reset_values done");
		for (j = 0; j < 4; j++) begin
			wr(0, {10'h200, 4'hf, j[1:0]});
			wr(5, {10'h1ff, 3'h7, j[0], ~j[1:0]});
			rd(0);
			rd(5);
		end
		repeat (60) begin
			k = {$random(seed)} % 7;
			wr(k, 16'($random(seed)));
			rd(k);
		end
		for (k = 0; k < 7; k++) rd(k);
		idle();
		$display("test register_access done");
		repeat (30) begin
			wr(1, 16'($signed($random(seed)) >>> 18));
			wr(2, 16'($random(seed)));
			wr(3, 16'($random(seed)));
			wr(4, 16'($random(seed)));
			repeat (3) smp(24'($signed($random(seed)) >>> 10));
		end
		wr(1, 16'h8000);
		wr(2, 16'h0000);
		wr(3, 16'hffff);
		wr(4, 16'hff00);
		smp(24'h7f_ffff);
		wr(1, 16'h7fff);
		wr(2, 16'hff00);
		smp(24'h80_0000);
		idle();
		$display("test correction done");
		i_srst <= 1;
		@(posedge i_sys_clk);
		i_srst <= 0;
		m = RST;
		for (k = 0; k < 7; k++) rd(k);
		idle();
		idle();
		$display("test second_reset done");
		end_sim();
	end
endmodule : accr_bank_bench
